// *** verilog/adcc_pkg.sv ***
// constants, register map and types for the a/d conversion control block
// assumes a single 10 mhz core clock and a plain register port
// Summary of operation
// - each shared port b/c pin is digital i/o or analog input per the pin select field.
// - the a/d interrupt reaches the core only with global and a/d enables both set.
// - a start bit written 0 then 1 then 0 begins a conversion.
// - the busy flag falls at conversion end and the result is then valid.
// - a conversion takes 76 periods of the a/d clock from the start pulse.
// - conversion runs in hardware and never stalls the processor.
// - a zero pin select field makes all pins digital and powers the converter down.
// - the result is 8-bit unsigned, full scale ff, one step is supply over 256.
// - the a/d interrupt vectors only with interrupts enabled and a free stack entry.
// - every converter setting comes from run-time register writes only.
// - start raised and left high holds the converter in reset with busy at one.
// - each conversion end sets the a/d interrupt request flag.
// - the a/d clock is the core clock divided by 2 for code 00 and by 8 for 01.
// - the channel select field routes one analog input, its top bit written zero.
package adcc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] REG_RESULT = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h1;
  localparam logic [3:0] REG_SETUP = 4'h2;
  localparam logic [3:0] REG_INT_CONTROL_REG = 4'h3;
  // control register fields
  localparam int CTRL_START_BIT = 7;
  localparam int CTRL_BUSY_BIT = 6;
  localparam int CTRL_CHAN_LSB = 0;
  // setup register fields
  localparam int SETUP_PIN_LSB = 4;
  localparam int SETUP_DIV_LSB = 0;
  // interrupt control fields
  localparam int INT_CONTROL_REG_GIE_BIT = 0;
  localparam int INT_CONTROL_REG_ADC_INT_ENABLE_BIT = 1;
  localparam int INT_CONTROL_REG_ADF_BIT = 2;
  // conversion timing in a/d clock periods
  localparam logic [6:0] CONV_TICKS = 7'h4c;
  localparam logic [6:0] SAR_FIRST_TICK = 7'h44;
  localparam logic [6:0] SAR_LAST_TICK = 7'h4b;
  localparam logic [7:0] SAR_INIT = 8'h80;
  // divider terminal counts
  localparam logic [1:0] DIV_SEL_2 = 2'h0;
  localparam logic [2:0] DIV2_LAST = 3'h1;
  localparam logic [2:0] DIV8_LAST = 3'h7;
  // reset values
  localparam logic [3:0] PIN_SEL_RESET = 4'h0;
  localparam logic [1:0] DIV_SEL_RESET = 2'h0;
  localparam logic [3:0] CHAN_RESET = 4'h0;
  localparam int NUM_PINS = 16;

  typedef enum logic [1:0] {
    ADCC_IDLE = 2'b00,
    ADCC_HOLD = 2'b01,
    ADCC_CONV = 2'b10
  } adcc_phase_e;
endpackage : adcc_pkg

// *** verilog/adcc_clk_div.sv ***
// a/d clock divider producing a one-cycle tick enable
// assumes run is low between conversions so each conversion starts aligned
`timescale 1ns/100ps
`default_nettype none
module adcc_clk_div (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic run_in,
  input wire logic [1:0] div_sel_in,
  output logic tick_out
);
  typedef struct packed {
    logic [2:0] cnt;
  } adcc_div_s;

  adcc_div_s s;
  adcc_div_s next_s;
  logic [2:0] last;

  // codes 10 and 11 are undefined, treated as divide by 8
  assign last = (div_sel_in == adcc_pkg::DIV_SEL_2) ?
                adcc_pkg::DIV2_LAST : adcc_pkg::DIV8_LAST;
  assign tick_out = run_in && (s.cnt == last);

  always_comb
  begin
    next_s = s;
    if (!run_in || tick_out)
    begin
      next_s.cnt = 3'h0;
    end
    else
    begin
      next_s.cnt = s.cnt + 3'h1;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence div2_run;
    run_in && div_sel_in == 2'h0;
  endsequence

  a_div_two_rate: assert property (
    (div2_run and tick_out) ##1 div2_run ##1 div2_run |->
    !$past(tick_out) && tick_out)
    else $error("divide by 2 tick spacing wrong");

  a_div_eight_gap: assert property (
    tick_out && div_sel_in == 2'h1 && run_in |=> !tick_out [*7])
    else $error("divide by 8 tick came early");
endmodule : adcc_clk_div
`default_nettype wire

// *** verilog/adcc_top.sv ***
// successive approximation a/d conversion control with its registers
// assumes an external comparator and dac front end and a plain register port
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module adcc_top #(
  parameter int NUM_PINS = adcc_pkg::NUM_PINS
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic comparator_in,
  input wire logic stack_free_in,
  output logic [7:0] dac_code_out,
  output logic [3:0] adc_channel_out,
  output logic [NUM_PINS-1:0] analog_pin_en_out,
  output logic adc_power_out,
  output logic adc_irq_out
);
  typedef struct packed {
    adcc_pkg::adcc_phase_e phase;
    logic start;
    logic conversion_busy_flag;
    logic [3:0] analog_channel_select;
    logic [3:0] analog_pin_select;
    logic [1:0] adc_clock_divider_select;
    logic global_int_enable;
    logic adc_int_enable;
    logic adc_int_request;
    logic [6:0] tick_cnt;
    logic [7:0] sar;
    logic [7:0] result;
    logic [7:0] rdata;
  } adcc_state_s;

  adcc_state_s s;
  adcc_state_s next_s;
  logic tick;
  logic done;
  logic powered;
  logic [7:0] sar_next;
  logic [2:0] bit_idx;

  // pin select n enables inputs 0..n, zero enables none
  function automatic logic [NUM_PINS-1:0] pin_mask(input logic [3:0] sel);
    logic [NUM_PINS-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_PINS; i++)
    begin
      if (sel != 4'h0 && i <= int'(sel))
      begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : pin_mask

  adcc_clk_div u_div (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .run_in(s.phase == adcc_pkg::ADCC_CONV),
    .div_sel_in(s.adc_clock_divider_select),
    .tick_out(tick)
  );

  assign powered = (s.analog_pin_select != 4'h0);
  assign adc_power_out = powered;
  assign analog_pin_en_out = pin_mask(s.analog_pin_select);
  assign adc_channel_out = s.analog_channel_select;
  assign dac_code_out = s.sar;
  assign reg_rdata_out = s.rdata;
  // request gated by both enables and a free stack entry
  assign adc_irq_out = s.global_int_enable && s.adc_int_enable &&
                       s.adc_int_request && stack_free_in;
  assign done = tick && (s.phase == adcc_pkg::ADCC_CONV) &&
                (s.tick_cnt == adcc_pkg::CONV_TICKS - 7'h1);
  assign bit_idx = 3'(adcc_pkg::SAR_LAST_TICK - s.tick_cnt);

  // one bit decided per a/d clock in the last eight periods
  always_comb
  begin
    sar_next = s.sar;
    if (s.tick_cnt >= adcc_pkg::SAR_FIRST_TICK &&
        s.tick_cnt <= adcc_pkg::SAR_LAST_TICK)
    begin
      if (!comparator_in)
      begin
        sar_next[bit_idx] = 1'b0;
      end
      if (bit_idx != 3'h0)
      begin
        sar_next[bit_idx - 3'h1] = 1'b1;
      end
    end
  end

  always_comb
  begin
    next_s = s;
    next_s.rdata = 8'h00;
    // all settings come from register writes, no fixed options
    if (reg_wr_in)
    begin
      case (reg_addr_in)
        adcc_pkg::REG_CTRL:
        begin
          next_s.analog_channel_select =
            reg_wdata_in[adcc_pkg::CTRL_CHAN_LSB +: 4];
          next_s.start = reg_wdata_in[adcc_pkg::CTRL_START_BIT];
          if (!s.start && reg_wdata_in[adcc_pkg::CTRL_START_BIT])
          begin
            next_s.phase = adcc_pkg::ADCC_HOLD;
            next_s.conversion_busy_flag = 1'b1;
          end
          else if (s.start && !reg_wdata_in[adcc_pkg::CTRL_START_BIT])
          begin
            if (powered)
            begin
              next_s.phase = adcc_pkg::ADCC_CONV;
              next_s.tick_cnt = 7'h00;
              next_s.sar = adcc_pkg::SAR_INIT;
            end
            else
            begin
              next_s.phase = adcc_pkg::ADCC_IDLE;
            end
          end
        end
        adcc_pkg::REG_SETUP:
        begin
          next_s.analog_pin_select =
            reg_wdata_in[adcc_pkg::SETUP_PIN_LSB +: 4];
          next_s.adc_clock_divider_select =
            reg_wdata_in[adcc_pkg::SETUP_DIV_LSB +: 2];
        end
        adcc_pkg::REG_INT_CONTROL_REG:
        begin
          next_s.global_int_enable = reg_wdata_in[adcc_pkg::INT_CONTROL_REG_GIE_BIT];
          next_s.adc_int_enable = reg_wdata_in[adcc_pkg::INT_CONTROL_REG_ADC_INT_ENABLE_BIT];
          next_s.adc_int_request = reg_wdata_in[adcc_pkg::INT_CONTROL_REG_ADF_BIT];
        end
        default:
        begin
          next_s.rdata = 8'h00;
        end
      endcase
    end
    // conversion advances on a/d clock ticks, the core keeps running
    if (s.phase == adcc_pkg::ADCC_CONV && next_s.phase == s.phase)
    begin
      if (!powered)
      begin
        next_s.phase = adcc_pkg::ADCC_IDLE;
      end
      else if (tick)
      begin
        next_s.sar = sar_next;
        next_s.tick_cnt = s.tick_cnt + 7'h1;
        if (done)
        begin
          next_s.result = sar_next;
          next_s.conversion_busy_flag = 1'b0;
          next_s.phase = adcc_pkg::ADCC_IDLE;
          next_s.tick_cnt = 7'h00;
        end
      end
    end
    // flag set by hardware wins over a software clear
    if (done && powered)
    begin
      next_s.adc_int_request = 1'b1;
    end
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        adcc_pkg::REG_RESULT:
        begin
          next_s.rdata = s.result;
        end
        adcc_pkg::REG_CTRL:
        begin
          next_s.rdata = {s.start, s.conversion_busy_flag, 2'b00,
                          s.analog_channel_select};
        end
        adcc_pkg::REG_SETUP:
        begin
          next_s.rdata = {s.analog_pin_select, 2'b00,
                          s.adc_clock_divider_select};
        end
        adcc_pkg::REG_INT_CONTROL_REG:
        begin
          next_s.rdata = {5'h00, s.adc_int_request, s.adc_int_enable,
                          s.global_int_enable};
        end
        default:
        begin
          next_s.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // checks
  logic [9:0] conv_clks;

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      conv_clks <= 10'h000;
    end
    else if (s.phase == adcc_pkg::ADCC_CONV)
    begin
      conv_clks <= conv_clks + 10'h001;
    end
    else
    begin
      conv_clks <= 10'h000;
    end
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence start_rise;
    reg_wr_in && reg_addr_in == 4'h1 && reg_wdata_in[7] && !s.start;
  endsequence

  sequence start_fall;
    reg_wr_in && reg_addr_in == 4'h1 && !reg_wdata_in[7] && s.start &&
    s.analog_pin_select != 4'h0;
  endsequence

  a_start_hold: assert property (
    start_rise |=> s.conversion_busy_flag &&
    s.phase == adcc_pkg::ADCC_HOLD)
    else $error("start rise did not hold converter");

  a_start_conv: assert property (
    start_fall |=> s.phase == adcc_pkg::ADCC_CONV &&
    s.conversion_busy_flag)
    else $error("start pulse did not begin conversion");

  a_conv_time: assert property (
    $fell(s.conversion_busy_flag) && $past(s.adc_clock_divider_select) ==
    2'h0 |-> $past(conv_clks) == 10'h097)
    else $error("conversion length not 76 a/d clocks");

  a_done_flag: assert property (
    $fell(s.conversion_busy_flag) |-> s.adc_int_request)
    else $error("end of conversion did not set request");

  a_result_valid: assert property (
    $fell(s.conversion_busy_flag) |-> s.result == $past(sar_next))
    else $error("result not updated with busy fall");

  a_irq_gating: assert property (
    adc_irq_out |-> s.global_int_enable && s.adc_int_enable)
    else $error("interrupt without both enables");

  a_stack_full: assert property (
    !stack_free_in |-> !adc_irq_out)
    else $error("interrupt with full stack");

  a_power_down: assert property (
    s.analog_pin_select == 4'h0 |-> !adc_power_out &&
    analog_pin_en_out == '0 ##1 s.phase != adcc_pkg::ADCC_CONV)
    else $error("zero pin select did not power down");

  a_result_read: assert property (
    reg_rd_in && reg_addr_in == 4'h0 |=> reg_rdata_out == $past(s.result))
    else $error("result read returned wrong data");

  a_conv_time_slow: assert property (
    $fell(s.conversion_busy_flag) && $past(s.adc_clock_divider_select) ==
    2'h1 |-> $past(conv_clks) == 10'h25f)
    else $error("slow conversion length not 76 a/d clocks");

  a_sar_start: assert property (
    start_fall |=> dac_code_out == adcc_pkg::SAR_INIT)
    else $error("conversion did not start at mid code");

  a_start_busy: assert property (
    s.start |-> s.conversion_busy_flag)
    else $error("start held high without busy");

  a_rdata_idle: assert property (
    !reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data not zero outside a read");
endmodule : adcc_top
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the a/d conversion control block
// assumes adcc_top with its registers on a plain strobe port, 10 mhz clock
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk, rstn, wr, rd, comp, stk;
  logic [3:0] addr, chan;
  logic [7:0] wdata, rdata, dac, ain;
  logic [15:0] pins;
  logic pwr, irq;
  int error_cnt, cmp_count, n;
  logic [3:0] u_sel [4] = '{4'h0, 4'h1, 4'h7, 4'hf};

  adcc_top u_adcc_top (
    .core_clk_in(clk), .resetn_in(rstn), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .comparator_in(comp), .stack_free_in(stk),
    .dac_code_out(dac), .adc_channel_out(chan),
    .analog_pin_en_out(pins), .adc_power_out(pwr), .adc_irq_out(irq)
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // front end: input at or above the trial code
  always @(posedge clk) comp <= (ain >= dac);

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, e});
  endtask : rd_reg

  // full conversion, counting clocks from the start release to the request
  task automatic conv(input logic [1:0] dv, input logic [3:0] ch,
                      input logic [7:0] a, input int ex);
    ain = a;
    wr_reg(adcc_pkg::REG_INT_CONTROL_REG, 8'h03);
    wr_reg(adcc_pkg::REG_SETUP, {6'h0c, dv});
    wr_reg(adcc_pkg::REG_CTRL, {4'h8, ch});
    rd_reg(adcc_pkg::REG_CTRL, {4'hc, ch});
    chk({12'h000, chan}, {12'h000, ch});
    wr_reg(adcc_pkg::REG_CTRL, {4'h0, ch});
    chk({8'h00, dac}, 16'h0080);
    n = 0;
    fork
      rd_reg(adcc_pkg::REG_SETUP, {6'h0c, dv});
      do
      begin
        @(posedge clk);
        #1;
        n++;
      end
      while (irq !== 1'b1 && n < 700);
    join
    chk(16'(n), 16'(ex));
    chk({8'h00, dac}, {8'h00, a});
    rd_reg(adcc_pkg::REG_CTRL, {4'h0, ch});
    rd_reg(adcc_pkg::REG_RESULT, a);
    rd_reg(adcc_pkg::REG_INT_CONTROL_REG, 8'h07);
  endtask : conv

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    #2000000;
    error_cnt++;
    wrap_up();
  end

  initial
  begin
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    stk = 1'b1;
    ain = 8'h00;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++)
      rd_reg(4'(i), 8'h00);
    rd_reg(4'h9, 8'h00);
    chk({15'h0000, pwr}, 16'h0000);
    // pin select sweep: pins 0..k analog, none for zero
    foreach (u_sel[i])
    begin
      wr_reg(adcc_pkg::REG_SETUP, {u_sel[i], 4'h0});
      chk(pins, u_sel[i] == 4'h0 ? 16'h0000 :
          16'hffff >> (4'hf - u_sel[i]));
      chk({15'h0000, pwr}, {15'h0000, u_sel[i] != 4'h0});
    end
    conv(2'h0, 4'h0, 8'hff, 152);
    conv(2'h1, 4'h5, 8'h5a, 608);
    conv(2'h0, 4'h7, 8'h00, 152);
    // interrupt gating on the pending request
    chk({15'h0000, irq}, 16'h0001);
    @(posedge clk);
    stk <= 1'b0;
    @(posedge clk);
    #1;
    chk({15'h0000, irq}, 16'h0000);
    @(posedge clk);
    stk <= 1'b1;
    wr_reg(adcc_pkg::REG_INT_CONTROL_REG, 8'h06);
    chk({15'h0000, irq}, 16'h0000);
    wr_reg(adcc_pkg::REG_INT_CONTROL_REG, 8'h05);
    chk({15'h0000, irq}, 16'h0000);
    wr_reg(adcc_pkg::REG_INT_CONTROL_REG, 8'h03);
    chk({15'h0000, irq}, 16'h0000);
    // result is read only
    wr_reg(adcc_pkg::REG_RESULT, 8'h33);
    rd_reg(adcc_pkg::REG_RESULT, 8'h00);
    // powered down: a start pulse converts nothing
    ain = 8'h40;
    wr_reg(adcc_pkg::REG_SETUP, 8'h00);
    chk({15'h0000, pwr}, 16'h0000);
    chk(pins, 16'h0000);
    wr_reg(adcc_pkg::REG_CTRL, 8'h80);
    wr_reg(adcc_pkg::REG_CTRL, 8'h00);
    repeat (300) @(posedge clk);
    rd_reg(adcc_pkg::REG_INT_CONTROL_REG, 8'h03);
    rd_reg(adcc_pkg::REG_RESULT, 8'h00);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
